// ==== rtl/spcr_pkg.sv ====
// Package with register map, field positions and carrier types of the port setup bank
package spcr_pkg;

    // Register offsets
    localparam logic [11:0] SPCR_ADDR_SETUP_A  = 12'h000;
    localparam logic [11:0] SPCR_ADDR_SETUP_B  = 12'h001;
    localparam logic [11:0] SPCR_ADDR_PART     = 12'h003;
    localparam logic [11:0] SPCR_ADDR_UNIT_LO  = 12'h004;
    localparam logic [11:0] SPCR_ADDR_UNIT_HI  = 12'h005;
    localparam logic [11:0] SPCR_ADDR_VARREV   = 12'h006;
    localparam logic [11:0] SPCR_ADDR_STD      = 12'h00b;
    localparam logic [11:0] SPCR_ADDR_MAKER_LO = 12'h00c;
    localparam logic [11:0] SPCR_ADDR_MAKER_HI = 12'h00d;
    localparam logic [11:0] SPCR_ADDR_COMMIT   = 12'h00f;

    // Field positions
    localparam int SPCR_A_SOFT_RST   = 0;
    localparam int SPCR_A_MSB_FIRST  = 1;
    localparam int SPCR_A_ADDR_UP    = 2;
    localparam int SPCR_B_SINGLE     = 7;
    localparam int SPCR_B_SPARE      = 6;
    localparam int SPCR_B_READ_BUF   = 5;
    localparam int SPCR_B_HOLD_RST   = 2;
    localparam int SPCR_C_COMMIT     = 0;

    // Reset values
    localparam logic [7:0] SPCR_RST_SETUP_A = 8'h00;
    localparam logic [7:0] SPCR_RST_SETUP_B = 8'h00;
    localparam logic [7:0] SPCR_RST_COMMIT  = 8'h00;
    localparam logic [3:0] SPCR_UNIT_LO_RSV = 4'hf;

    // Identity values, all arbitrary
    localparam logic [3:0]  SPCR_PART_KIND  = 4'ha;
    localparam logic [11:0] SPCR_UNIT_IDENT = 12'h3c7;
    localparam logic [3:0]  SPCR_VARIANT    = 4'h2;
    localparam logic [3:0]  SPCR_REVISION   = 4'h3;
    localparam logic [7:0]  SPCR_STD_LEVEL  = 8'h07;
    localparam logic [15:0] SPCR_MAKER_CODE = 16'h9e21;

    // Soft reset countdown start; the pulse is held one cycle more than this
    localparam logic [3:0] SPCR_SOFT_RST_CYC = 4'h4;

    // Register access request from the serial port engine
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } spcr_req_t;

    // Control outputs toward the serial engine and core
    typedef struct packed {
        logic addr_up;
        logic msb_first;
        logic single_instr;
        logic read_buf;
        logic chip_reset;
        logic hold_reset;
        logic commit;
    } spcr_ctrl_t;

endpackage

// ==== rtl/spcr_id_rom.sv ====
// Read-only identification bytes of the port setup bank
`timescale 1ns/100ps
`default_nettype none
module spcr_id_rom
    import spcr_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic [11:0] addr_i,
    output logic [7:0]       data_o,
    output logic             hit_o
);

    typedef struct packed {
        logic [7:0] data;
        logic       hit;
    } spcr_rom_st_t;

    spcr_rom_st_t st_q;
    spcr_rom_st_t st_d;

    // Identity byte lookup
    always_comb begin
        st_d = '0;
        st_d.hit = 1'b1;
        case (addr_i)
            SPCR_ADDR_PART:     st_d.data = {4'h0, SPCR_PART_KIND};
            SPCR_ADDR_UNIT_LO:  st_d.data = {SPCR_UNIT_IDENT[3:0], SPCR_UNIT_LO_RSV};
            SPCR_ADDR_UNIT_HI:  st_d.data = SPCR_UNIT_IDENT[11:4];
            SPCR_ADDR_VARREV:   st_d.data = {SPCR_VARIANT, SPCR_REVISION};
            SPCR_ADDR_STD:      st_d.data = SPCR_STD_LEVEL;
            SPCR_ADDR_MAKER_LO: st_d.data = SPCR_MAKER_CODE[7:0];
            SPCR_ADDR_MAKER_HI: st_d.data = SPCR_MAKER_CODE[15:8];
            default:            st_d.hit = 1'b0;
        endcase
    end

    // Registered read data
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign data_o = st_q.data;
    assign hit_o  = st_q.hit;

endmodule
`default_nettype wire

// ==== rtl/spcr_bit_order.sv ====
// Readback serializer order selection for one data byte
`timescale 1ns/100ps
`default_nettype none
module spcr_bit_order
    import spcr_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic       load_i,
    input  wire logic [7:0] byte_i,
    input  wire logic       msb_first_i,
    input  wire logic       i2c_mode_i,
    output logic [7:0]      byte_o
);

    typedef struct packed {
        logic [7:0] ordered;
    } spcr_ord_st_t;

    spcr_ord_st_t st_q;
    spcr_ord_st_t st_d;

    function automatic logic [7:0] spcr_rev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction

    // Output byte is shifted out from bit 7; I2C always sends MSB first
    always_comb begin
        st_d = st_q;
        if (load_i) begin
            if (msb_first_i || i2c_mode_i) begin
                st_d.ordered = byte_i;
            end else begin
                st_d.ordered = spcr_rev8(byte_i);
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign byte_o = st_q.ordered;

endmodule
`default_nettype wire

// ==== rtl/spcr_regs.sv ====
// Serial port configuration and identification register bank
`timescale 1ns/100ps
`default_nettype none
module spcr_regs
    import spcr_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic        i2c_mode_i,
    input  wire logic        req_wr_i,
    input  wire logic        req_rd_i,
    input  wire logic [11:0] req_addr_i,
    input  wire logic [7:0]  req_wdata_i,
    input  wire logic        xfer_start_i,
    input  wire logic        byte_done_i,
    input  wire logic [11:0] start_addr_i,
    input  wire logic [7:0]  ext_buf_rdata_i,
    input  wire logic [7:0]  ext_act_rdata_i,
    output logic [7:0]       rdata_o,
    output logic             rvalid_o,
    output logic [7:0]       rdata_ser_o,
    output logic [11:0]      ptr_o,
    output logic             need_instr_o,
    output logic             chip_reset_o,
    output logic             hold_reset_o,
    output logic             commit_o,
    output logic             msb_first_o,
    output logic             read_buf_o
);

    // Whole bank state
    typedef struct packed {
        logic        soft_rst;
        logic [3:0]  rst_cnt;
        logic        msb_first;
        logic        addr_up;
        logic        single;
        logic        spare;
        logic        read_buf;
        logic        hold_rst;
        logic        commit;
        logic [11:0] ptr;
        logic        need_instr;
        logic        rd_pend;
        logic        rd_local;
        logic [7:0]  rd_local_data;
        logic        rd_id;
        logic        rd_sel_buf;
        logic        rvalid;
        logic [7:0]  rdata;
        logic        ser_load;
        logic        chip_reset;
    } spcr_st_t;

    spcr_st_t   st_q;
    spcr_st_t   st_d;
    spcr_req_t  req;
    logic [7:0] id_data;
    logic       id_hit;
    logic [7:0] ser_byte;

    assign req.wr    = req_wr_i;
    assign req.rd    = req_rd_i;
    assign req.addr  = req_addr_i;
    assign req.wdata = req_wdata_i;

    function automatic logic [7:0] spcr_setup_a(input logic sr, input logic lf,
                                                input logic up);
        // Symmetric layout, readable in either bit order
        return {sr, lf, up, 2'b00, up, lf, sr};
    endfunction

    function automatic logic [11:0] spcr_step(input logic [11:0] p, input logic up);
        if (up) begin
            return 12'(p + 12'h001);
        end
        return 12'(p - 12'h001);
    endfunction

    // Identity bytes
    spcr_id_rom u_id_rom (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .addr_i    (req.addr),
        .data_o    (id_data),
        .hit_o     (id_hit)
    );

    // Bit-ordered copy of read data for the shifter
    spcr_bit_order u_bit_order (
        .clk_sys_i   (clk_sys_i),
        .resetn_i    (resetn_i),
        .load_i      (st_q.ser_load),
        .byte_i      (st_q.rdata),
        .msb_first_i (st_q.msb_first),
        .i2c_mode_i  (i2c_mode_i),
        .byte_o      (ser_byte)
    );

    // Next state of the bank
    always_comb begin
        st_d = st_q;
        st_d.commit   = 1'b0;
        st_d.rvalid   = 1'b0;
        st_d.ser_load = 1'b0;
        st_d.rd_pend  = 1'b0;

        // Soft reset pulse: clears setup bits, counts down, then releases
        if (st_q.soft_rst) begin
            if (st_q.rst_cnt == 4'h0) begin
                st_d.soft_rst = 1'b0;
            end else begin
                st_d.rst_cnt = 4'(st_q.rst_cnt - 4'h1);
            end
        end

        // Register writes, ignored while soft reset runs
        if (req.wr && !st_q.soft_rst) begin
            case (req.addr)
                SPCR_ADDR_SETUP_A: begin
                    // Either mirror copy of a bit sets it
                    st_d.soft_rst  = req.wdata[SPCR_A_SOFT_RST] | req.wdata[7];
                    st_d.msb_first = req.wdata[SPCR_A_MSB_FIRST] | req.wdata[6];
                    st_d.addr_up   = req.wdata[SPCR_A_ADDR_UP] | req.wdata[5];
                    st_d.rst_cnt   = SPCR_SOFT_RST_CYC;
                end
                SPCR_ADDR_SETUP_B: begin
                    st_d.single   = req.wdata[SPCR_B_SINGLE];
                    st_d.spare    = req.wdata[SPCR_B_SPARE];
                    st_d.read_buf = req.wdata[SPCR_B_READ_BUF];
                    st_d.hold_rst = req.wdata[SPCR_B_HOLD_RST];
                end
                SPCR_ADDR_COMMIT: begin
                    st_d.commit = req.wdata[SPCR_C_COMMIT];
                end
                default: begin
                end
            endcase
        end

        // Soft reset returns the setup bits to their defaults
        if (st_q.soft_rst) begin
            st_d.msb_first = SPCR_RST_SETUP_A[SPCR_A_MSB_FIRST];
            st_d.addr_up   = SPCR_RST_SETUP_A[SPCR_A_ADDR_UP];
            st_d.single    = SPCR_RST_SETUP_B[SPCR_B_SINGLE];
            st_d.spare     = SPCR_RST_SETUP_B[SPCR_B_SPARE];
            st_d.read_buf  = SPCR_RST_SETUP_B[SPCR_B_READ_BUF];
            st_d.hold_rst  = SPCR_RST_SETUP_B[SPCR_B_HOLD_RST];
        end

        // Chip reset while soft reset runs
        st_d.chip_reset = st_d.soft_rst;

        // Address pointer for multibyte transfers
        if (xfer_start_i) begin
            st_d.ptr        = start_addr_i;
            st_d.need_instr = 1'b0;
        end else if (byte_done_i) begin
            if (st_q.single) begin
                st_d.need_instr = 1'b1;
            end else begin
                st_d.ptr = spcr_step(st_q.ptr, st_q.addr_up);
            end
        end

        // Read first stage: local setup bytes and source select
        if (req.rd) begin
            st_d.rd_pend    = 1'b1;
            st_d.rd_id      = 1'b0;
            st_d.rd_local   = 1'b1;
            st_d.rd_sel_buf = st_q.read_buf;
            case (req.addr)
                SPCR_ADDR_SETUP_A:
                    st_d.rd_local_data = spcr_setup_a(st_q.soft_rst, st_q.msb_first,
                                                      st_q.addr_up);
                SPCR_ADDR_SETUP_B:
                    st_d.rd_local_data = {st_q.single, st_q.spare, st_q.read_buf, 2'b00,
                                          st_q.hold_rst, 2'b00};
                SPCR_ADDR_COMMIT:
                    st_d.rd_local_data = 8'h00; // Commit bit reads back cleared
                default: begin
                    st_d.rd_local      = 1'b0;
                    st_d.rd_id         = 1'b1;
                    st_d.rd_local_data = 8'h00;
                end
            endcase
        end

        // Read second stage: pick the answer
        if (st_q.rd_pend) begin
            st_d.rvalid   = 1'b1;
            st_d.ser_load = 1'b1;
            if (st_q.rd_local) begin
                st_d.rdata = st_q.rd_local_data;
            end else if (st_q.rd_id && id_hit) begin
                st_d.rdata = id_data;
            end else if (st_q.rd_sel_buf) begin
                st_d.rdata = ext_buf_rdata_i;
            end else begin
                st_d.rdata = ext_act_rdata_i;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flip-flops
    assign rdata_o      = st_q.rdata;
    assign rvalid_o     = st_q.rvalid;
    assign rdata_ser_o  = ser_byte;
    assign ptr_o        = st_q.ptr;
    assign need_instr_o = st_q.need_instr;
    assign chip_reset_o = st_q.chip_reset;
    assign hold_reset_o = st_q.hold_rst;
    assign commit_o     = st_q.commit;
    assign msb_first_o  = st_q.msb_first;
    assign read_buf_o   = st_q.read_buf;

endmodule
`default_nettype wire

// ==== verification/spcr_core_model.sv ====
// Core register copies behind the bank, buffered and active
`timescale 1ns/100ps
`default_nettype none
module spcr_core_model (
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic        req_wr_i,
    input  wire logic [11:0] req_addr_i,
    input  wire logic [7:0]  req_wdata_i,
    input  wire logic        commit_i,
    output logic [7:0]       buf_rdata_o,
    output logic [7:0]       act_rdata_o
);
    logic [7:0] buf_q [16];
    logic [7:0] act_q [16];
    // Host writes above 0x0ff land in the buffered copy, commit moves all to active
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < 16; i++) begin
                buf_q[i] <= 8'h40 + 8'(i);
                act_q[i] <= 8'h80 + 8'(i);
            end
        end else begin
            if (commit_i) begin
                act_q <= buf_q;
            end
            if (req_wr_i && req_addr_i[11:8] != 4'h0) begin
                buf_q[req_addr_i[3:0]] <= req_wdata_i;
            end
        end
    end
    // Both copies answer for the addressed register
    assign buf_rdata_o = buf_q[req_addr_i[3:0]];
    assign act_rdata_o = act_q[req_addr_i[3:0]];
endmodule
`default_nettype wire

// ==== verification/spcr_regs_sva.sv ====
// Port-level checker of the port setup register bank
`timescale 1ns/100ps
`default_nettype none
module spcr_regs_sva
    import spcr_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic        i2c_mode_i,
    input  wire logic        req_wr_i,
    input  wire logic        req_rd_i,
    input  wire logic [11:0] req_addr_i,
    input  wire logic [7:0]  req_wdata_i,
    input  wire logic        xfer_start_i,
    input  wire logic        byte_done_i,
    input  wire logic [11:0] start_addr_i,
    input  wire logic [7:0]  rdata_o,
    input  wire logic        rvalid_o,
    input  wire logic [7:0]  rdata_ser_o,
    input  wire logic [11:0] ptr_o,
    input  wire logic        need_instr_o,
    input  wire logic        chip_reset_o,
    input  wire logic        hold_reset_o,
    input  wire logic        commit_o,
    input  wire logic        msb_first_o,
    input  wire logic        read_buf_o
);
    logic [7:0]  wd_q;
    logic [7:0]  rd_q;
    logic [11:0] sa_q;
    logic        ord_q;
    logic [7:0]  rv_q;
    logic        wa;
    logic        wb;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // Accepted writes to the two setup registers
    assign wa = req_wr_i && !chip_reset_o && req_addr_i == SPCR_ADDR_SETUP_A;
    assign wb = req_wr_i && !chip_reset_o && req_addr_i == SPCR_ADDR_SETUP_B;
    // One-cycle copies of causes
    always_ff @(posedge clk_sys_i) begin
        wd_q  <= req_wdata_i;
        rd_q  <= rdata_o;
        rv_q  <= {<<{rdata_o}}; // Bit-reversed copy for LSB-first readback
        sa_q  <= start_addr_i;
        ord_q <= msb_first_o || i2c_mode_i;
    end
    property p_soft_set;
        wa && (req_wdata_i[0] || req_wdata_i[7]) |=> chip_reset_o;
    endproperty
    a_soft_set: assert property (p_soft_set) else $error("soft reset not started");
    property p_soft_end;
        $rose(chip_reset_o) |-> ##[1:12] !chip_reset_o;
    endproperty
    a_soft_end: assert property (p_soft_end) else $error("soft reset stuck");
    property p_mirror;
        wa && !req_wdata_i[0] && !req_wdata_i[7] |=> msb_first_o == (wd_q[1] || wd_q[6]);
    endproperty
    a_mirror: assert property (p_mirror) else $error("bit order not set");
    property p_setup_b;
        wb |=> read_buf_o == wd_q[5] && hold_reset_o == wd_q[2];
    endproperty
    a_setup_b: assert property (p_setup_b) else $error("setup b bits wrong");
    property p_commit;
        req_wr_i && !chip_reset_o && req_addr_i == SPCR_ADDR_COMMIT && req_wdata_i[0]
            |=> commit_o ##1 !commit_o;
    endproperty
    a_commit: assert property (p_commit) else $error("commit pulse wrong");
    property p_part;
        req_rd_i && req_addr_i == SPCR_ADDR_PART |-> ##2 rdata_o == {4'h0, SPCR_PART_KIND};
    endproperty
    a_part: assert property (p_part) else $error("part kind wrong");
    property p_xfer;
        xfer_start_i |=> !need_instr_o && ptr_o == sa_q;
    endproperty
    a_xfer: assert property (p_xfer) else $error("pointer load wrong");
    property p_need;
        $rose(need_instr_o) |-> $past(byte_done_i);
    endproperty
    a_need: assert property (p_need) else $error("instruction demand without byte");
    property p_ser;
        rvalid_o |=> rdata_ser_o == (ord_q ? rd_q : rv_q);
    endproperty
    a_ser: assert property (p_ser) else $error("readback order wrong");
    c_commit: cover property (commit_o);
    c_soft: cover property ($fell(chip_reset_o));
    c_need: cover property (need_instr_o);
endmodule
bind spcr_regs spcr_regs_sva u_sva (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .i2c_mode_i(i2c_mode_i),
    .req_wr_i(req_wr_i), .req_rd_i(req_rd_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .xfer_start_i(xfer_start_i), .byte_done_i(byte_done_i),
    .start_addr_i(start_addr_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .rdata_ser_o(rdata_ser_o), .ptr_o(ptr_o), .need_instr_o(need_instr_o),
    .chip_reset_o(chip_reset_o), .hold_reset_o(hold_reset_o), .commit_o(commit_o),
    .msb_first_o(msb_first_o), .read_buf_o(read_buf_o)
);
`default_nettype wire

// ==== verification/tb_spcr_regs.sv ====
// Self-checking bench for the port setup register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
    $display("[FAIL] %0t mismatch %h %h", $time, got, exp); end end
module tb_spcr_regs
    import spcr_pkg::*;
;
    logic        clk_sys_i = 1'b0, resetn_i = 1'b0, i2c_mode_i = 1'b0;
    logic        req_wr_i = 1'b0, req_rd_i = 1'b0, xfer_start_i = 1'b0, byte_done_i = 1'b0;
    logic [11:0] req_addr_i = 12'h000, start_addr_i = 12'h000;
    logic [7:0]  req_wdata_i = 8'h00, r, s, rv;
    logic [7:0]  ext_buf, ext_act, rdata_o, rdata_ser_o;
    logic [11:0] ptr_o;
    logic        rvalid_o, need_instr_o, chip_reset_o, hold_reset_o, commit_o;
    logic        msb_first_o, read_buf_o;
    int          n_fail = 0, check_count = 0;
    logic [11:0] id_a [7] = '{SPCR_ADDR_PART, SPCR_ADDR_UNIT_LO, SPCR_ADDR_UNIT_HI,
        SPCR_ADDR_VARREV, SPCR_ADDR_STD, SPCR_ADDR_MAKER_LO, SPCR_ADDR_MAKER_HI};
    logic [7:0]  id_e [7] = '{{4'h0, SPCR_PART_KIND}, {SPCR_UNIT_IDENT[3:0], SPCR_UNIT_LO_RSV},
        SPCR_UNIT_IDENT[11:4], {SPCR_VARIANT, SPCR_REVISION}, SPCR_STD_LEVEL,
        SPCR_MAKER_CODE[7:0], SPCR_MAKER_CODE[15:8]};
    always #5 clk_sys_i = ~clk_sys_i;
    spcr_regs dut (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .i2c_mode_i(i2c_mode_i),
        .req_wr_i(req_wr_i), .req_rd_i(req_rd_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .xfer_start_i(xfer_start_i), .byte_done_i(byte_done_i),
        .start_addr_i(start_addr_i), .ext_buf_rdata_i(ext_buf), .ext_act_rdata_i(ext_act),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .rdata_ser_o(rdata_ser_o), .ptr_o(ptr_o),
        .need_instr_o(need_instr_o), .chip_reset_o(chip_reset_o),
        .hold_reset_o(hold_reset_o), .commit_o(commit_o), .msb_first_o(msb_first_o),
        .read_buf_o(read_buf_o)
    );
    spcr_core_model u_core (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_wr_i(req_wr_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .commit_i(commit_o),
        .buf_rdata_o(ext_buf), .act_rdata_o(ext_act)
    );
    // Verdict and end of run
    task automatic end_sim();
        if (n_fail == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One-byte write, strobe for one cycle
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        req_addr_i = a;
        req_wdata_i = d;
        req_wr_i = 1'b1;
        @(negedge clk_sys_i);
        req_wr_i = 1'b0;
        @(negedge clk_sys_i);
    endtask
    // One-byte read, then compare answer
    task automatic cr(input logic [11:0] a, input logic [7:0] e);
        int i;
        req_addr_i = a;
        req_rd_i = 1'b1;
        @(negedge clk_sys_i);
        req_rd_i = 1'b0;
        for (i = 0; i < 8 && rvalid_o !== 1'b1; i++) @(negedge clk_sys_i);
        if (i == 8) begin
            n_fail++;
            end_sim();
        end
        r = rdata_o;
        @(negedge clk_sys_i);
        s = rdata_ser_o;
        `CHK(r, e)
    endtask
    // Transfer start and byte completion pulses
    task automatic tick(input logic st, input logic bd);
        xfer_start_i = st;
        byte_done_i = bd;
        @(negedge clk_sys_i);
        xfer_start_i = 1'b0;
        byte_done_i = 1'b0;
        @(negedge clk_sys_i);
    endtask
    initial begin
        repeat (20) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        @(negedge clk_sys_i);
        // Reset values, identity bytes after writes that must not stick
        cr(SPCR_ADDR_SETUP_A, SPCR_RST_SETUP_A);
        cr(SPCR_ADDR_SETUP_B, SPCR_RST_SETUP_B);
        cr(SPCR_ADDR_COMMIT, SPCR_RST_COMMIT);
        wr(SPCR_ADDR_PART, 8'hff);
        wr(SPCR_ADDR_MAKER_LO, 8'hff);
        for (int k = 0; k < 7; k++) cr(id_a[k], id_e[k]);
        // Mirror bits and readback order in both settings and in I2C
        wr(SPCR_ADDR_SETUP_A, 8'h06);
        `CHK(msb_first_o, 1'b1)
        cr(SPCR_ADDR_SETUP_A, 8'h66);
        cr(SPCR_ADDR_MAKER_LO, SPCR_MAKER_CODE[7:0]);
        `CHK(s, r)
        wr(SPCR_ADDR_SETUP_A, 8'h20);
        cr(SPCR_ADDR_SETUP_A, 8'h24);
        cr(SPCR_ADDR_MAKER_LO, SPCR_MAKER_CODE[7:0]);
        rv = {<<{SPCR_MAKER_CODE[7:0]}};
        `CHK(s, rv)
        i2c_mode_i = 1'b1;
        cr(SPCR_ADDR_MAKER_LO, SPCR_MAKER_CODE[7:0]);
        `CHK(s, r)
        i2c_mode_i = 1'b0;
        // Pointer up, then down across zero
        start_addr_i = 12'h010;
        tick(1'b1, 1'b0);
        tick(1'b0, 1'b1);
        tick(1'b0, 1'b1);
        `CHK(ptr_o, 12'h012)
        wr(SPCR_ADDR_SETUP_A, 8'h00);
        start_addr_i = 12'h000;
        tick(1'b1, 1'b0);
        tick(1'b0, 1'b1);
        `CHK(ptr_o, 12'hfff)
        // Single instruction: each byte asks for a new instruction
        wr(SPCR_ADDR_SETUP_B, 8'h80);
        tick(1'b1, 1'b0);
        tick(1'b0, 1'b1);
        `CHK(need_instr_o, 1'b1)
        `CHK(ptr_o, 12'h000)
        tick(1'b1, 1'b0);
        `CHK(need_instr_o, 1'b0)
        // Read source and commit of buffered copies
        wr(SPCR_ADDR_SETUP_B, 8'h20);
        `CHK(read_buf_o, 1'b1)
        wr(12'h101, 8'h5a);
        cr(12'h101, 8'h5a);
        wr(SPCR_ADDR_SETUP_B, 8'h00);
        cr(12'h101, 8'h81);
        // Commit pulse stands one cycle only, so look at it inside the write
        req_addr_i = SPCR_ADDR_COMMIT;
        req_wdata_i = 8'h01;
        req_wr_i = 1'b1;
        @(negedge clk_sys_i);
        req_wr_i = 1'b0;
        `CHK(commit_o, 1'b1)
        @(negedge clk_sys_i);
        `CHK(commit_o, 1'b0)
        cr(SPCR_ADDR_COMMIT, 8'h00);
        cr(12'h101, 8'h5a);
        // Map-keeping reset keeps contents
        wr(SPCR_ADDR_SETUP_A, 8'h04);
        wr(SPCR_ADDR_SETUP_B, 8'h04);
        `CHK(hold_reset_o, 1'b1)
        cr(SPCR_ADDR_SETUP_A, 8'h24);
        wr(SPCR_ADDR_SETUP_B, 8'h00);
        `CHK(hold_reset_o, 1'b0)
        // Soft reset clears setup, ignores writes while active
        wr(SPCR_ADDR_SETUP_B, 8'h04);
        wr(SPCR_ADDR_SETUP_A, 8'h01);
        `CHK(chip_reset_o, 1'b1)
        wr(SPCR_ADDR_SETUP_B, 8'h20);
        for (int i = 0; i < 20 && chip_reset_o === 1'b1; i++) @(negedge clk_sys_i);
        `CHK(chip_reset_o, 1'b0)
        if (chip_reset_o !== 1'b0) begin
            end_sim();
        end
        cr(SPCR_ADDR_SETUP_A, 8'h00);
        cr(SPCR_ADDR_SETUP_B, 8'h00);
        `CHK(hold_reset_o, 1'b0)
        end_sim();
    end
endmodule
`default_nettype wire
